// file: src/lprt_pkg.sv
package lprt_pkg;

  // device variants
  typedef enum logic [1:0] {
    LPRT_VAR_LEVEL = 2'h0,
    LPRT_VAR_PULSE2 = 2'h1,
    LPRT_VAR_PULSE1 = 2'h2
  } lprt_variant_e;

  // times in their own units
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned STARTUP_US = 300;
  localparam int unsigned HOLD_LONG_LEVEL_MS = 12500;
  localparam int unsigned HOLD_SHORT_MS = 7500;
  localparam int unsigned HOLD_ZERO_MS = 0;
  localparam int unsigned PULSE_MS = 400;

  // cycles per timebase tick (1 ms)
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  // start-up delay in clock cycles, clock rounded down to whole MHz
  localparam int unsigned STARTUP_CYCLES = (CLK_HZ / 1000000) * STARTUP_US;

  localparam int TICK_W = 16;
  localparam int MS_W = 14;

  typedef logic [TICK_W-1:0] lprt_tick_t;
  typedef logic [MS_W-1:0] lprt_ms_t;

  // filtered inputs
  typedef struct packed {
    logic btnA;
    logic btnB;
  } lprt_buttons_s;

  // open-drain pin: out value and active-low enable
  typedef struct packed {
    logic pinOut;
    logic pinOe_b;
  } lprt_od_s;

endpackage : lprt_pkg

// file: src/lprt_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin levels
module lprt_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rstSync_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lprt_sync_s;

  lprt_sync_s state_reg;
  lprt_sync_s state_next;

  always_comb begin
    state_next.meta = din;
    state_next.stable = state_reg.meta;
  end

  // buttons idle high; reset value avoids a false press
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_reg <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.stable;

endmodule : lprt_sync

// file: src/lprt_timebase.sv
`timescale 1ns/1ps
// free-running slow tick, one cycle wide
module lprt_timebase #(
  parameter int unsigned TICK_CYCLES = lprt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstSync_b,
  output logic tick
);

  typedef struct packed {
    lprt_pkg::lprt_tick_t count;
    logic tick;
  } lprt_tb_s;

  lprt_tb_s state_reg;
  lprt_tb_s state_next;

  localparam lprt_pkg::lprt_tick_t LAST = lprt_pkg::lprt_tick_t'(TICK_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.count == LAST) begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule : lprt_timebase

// file: src/lprt_top.sv
`timescale 1ns/1ps
// Behaviour
// - level variant: reset low after both held for hold time, release on any high
// - dual pulse variant: both held for hold time gives one fixed pulse
// - single variant: one held for hold time gives one fixed pulse
// - strap picks hold time; level variant 12.5 s high, 7.5 s low
// - pulse variants: 0 s strap high, 7.5 s strap low, pulse 400 ms
// - strap sampled at start-up and while any input is high only
// - dual variants: one reset per hold; re-arm needs a release first
// - single variant: re-arm needs input released then held again
// - glitches on inputs during a fixed pulse are ignored
// - input rising during pulse is acted on after the pulse ends
// - reset output open-drain, active low, released means undriven
// - after start-up delay the output follows the inputs
// - low supply range behaves the same, timing not exact
// - during power-on reset the output is undriven
// - inputs already low at start-up assert only after start-up delay
module lprt_top #(
  parameter lprt_pkg::lprt_variant_e VARIANT = lprt_pkg::LPRT_VAR_PULSE2,
  parameter int unsigned TICK_CYCLES = lprt_pkg::TICK_CYCLES,
  parameter int unsigned STARTUP_CYCLES = lprt_pkg::STARTUP_CYCLES,
  parameter int unsigned HOLD_HIGH_MS = (VARIANT == lprt_pkg::LPRT_VAR_LEVEL) ?
      lprt_pkg::HOLD_LONG_LEVEL_MS : lprt_pkg::HOLD_ZERO_MS,
  parameter int unsigned HOLD_LOW_MS = lprt_pkg::HOLD_SHORT_MS,
  parameter int unsigned PULSE_MS = lprt_pkg::PULSE_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic buttonInA_b,
  input wire logic buttonInB_b,
  input wire logic holdTimeStrap,
  input wire logic resetIn,
  output logic resetOut,
  output logic resetOe_b
);

  typedef enum logic [3:0] {
    ST_STARTUP = 4'h1,
    ST_ARMED = 4'h2,
    ST_ASSERT = 4'h4,
    ST_WAIT_RELEASE = 4'h8
  } lprt_state_e;

  typedef struct packed {
    logic rstMeta;
    logic rstSync;
  } lprt_rst_s;

  typedef struct packed {
    lprt_state_e fsm;
    logic [15:0] startCount;
    lprt_pkg::lprt_ms_t msCount;
    logic strapLatched;
    logic resetActive;
  } lprt_core_s;

  lprt_rst_s rst_reg;
  lprt_core_s core_reg;
  lprt_core_s core_next;
  logic rstSync_b;
  logic [2:0] syncOut;
  lprt_pkg::lprt_buttons_s buttons;
  logic strapNow;
  logic tick;
  logic pressed;
  logic anyHigh;
  lprt_pkg::lprt_ms_t holdMs;
  lprt_pkg::lprt_od_s od;

  localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYCLES - 1);
  localparam lprt_pkg::lprt_ms_t HOLD_HI = lprt_pkg::lprt_ms_t'(HOLD_HIGH_MS);
  localparam lprt_pkg::lprt_ms_t HOLD_LO = lprt_pkg::lprt_ms_t'(HOLD_LOW_MS);
  localparam lprt_pkg::lprt_ms_t PULSE_LAST = lprt_pkg::lprt_ms_t'(PULSE_MS - 1);
  localparam bit DUAL = (VARIANT != lprt_pkg::LPRT_VAR_PULSE1);
  localparam bit LEVEL = (VARIANT == lprt_pkg::LPRT_VAR_LEVEL);

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_reg <= '0;
    end else begin
      rst_reg.rstMeta <= 1'b1;
      rst_reg.rstSync <= rst_reg.rstMeta;
    end
  end
  assign rstSync_b = rst_reg.rstSync;

  lprt_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .din({buttonInA_b, buttonInB_b, holdTimeStrap}),
    .dout(syncOut)
  );

  lprt_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .tick(tick)
  );

  assign buttons.btnA = syncOut[2];
  // single variant ignores the second input
  assign buttons.btnB = DUAL ? syncOut[1] : 1'b0;
  assign strapNow = syncOut[0];
  assign pressed = !buttons.btnA && !buttons.btnB;
  assign anyHigh = !pressed;

  function automatic lprt_pkg::lprt_ms_t holdFor(input logic strap);
    holdFor = strap ? HOLD_HI : HOLD_LO;
  endfunction : holdFor

  assign holdMs = holdFor(core_reg.strapLatched);

  always_comb begin
    core_next = core_reg;
    // strap follows pin while an input is high or during start-up
    if (anyHigh || core_reg.fsm == ST_STARTUP) begin
      core_next.strapLatched = strapNow;
    end
    unique case (core_reg.fsm)
      ST_STARTUP: begin
        core_next.resetActive = 1'b0;
        if (core_reg.startCount == STARTUP_LAST) begin
          core_next.fsm = ST_ARMED;
          core_next.msCount = '0;
        end else begin
          core_next.startCount = core_reg.startCount + 1'b1;
        end
      end
      ST_ARMED: begin
        // no supply sensing: output follows inputs whenever out of start-up
        if (!pressed) begin
          core_next.msCount = '0;
        end else if (core_reg.msCount >= holdMs) begin
          core_next.fsm = ST_ASSERT;
          core_next.resetActive = 1'b1;
          core_next.msCount = '0;
        end else if (tick) begin
          core_next.msCount = core_reg.msCount + 1'b1;
        end
      end
      ST_ASSERT: begin
        if (LEVEL) begin
          if (!pressed) begin
            core_next.fsm = ST_ARMED;
            core_next.resetActive = 1'b0;
            core_next.msCount = '0;
          end
        end else if (tick) begin
          // inputs are not looked at during the pulse
          if (core_reg.msCount == PULSE_LAST) begin
            core_next.fsm = ST_WAIT_RELEASE;
            core_next.resetActive = 1'b0;
            core_next.msCount = '0;
          end else begin
            core_next.msCount = core_reg.msCount + 1'b1;
          end
        end
      end
      ST_WAIT_RELEASE: begin
        if (!pressed) begin
          core_next.fsm = ST_ARMED;
        end
      end
      default: begin
        core_next.fsm = ST_STARTUP;
        core_next.resetActive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      core_reg.fsm <= ST_STARTUP;
      core_reg.startCount <= '0;
      core_reg.msCount <= '0;
      core_reg.strapLatched <= 1'b0;
      core_reg.resetActive <= 1'b0;
    end else begin
      core_reg <= core_next;
    end
  end

  // open-drain: pull low when asserted, otherwise undriven
  assign od.pinOut = 1'b0;
  assign od.pinOe_b = !core_reg.resetActive;
  assign resetOut = od.pinOut;
  assign resetOe_b = od.pinOe_b;

endmodule : lprt_top

// file: tb/lprt_top_chk_sva.sv
`timescale 1ns/1ps
module lprt_top_chk #(
  parameter lprt_pkg::lprt_variant_e VARIANT = lprt_pkg::LPRT_VAR_PULSE2,
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned STARTUP_CYCLES = 8,
  parameter int unsigned HOLD_HIGH_MS = 0,
  parameter int unsigned HOLD_LOW_MS = 6,
  parameter int unsigned PULSE_MS = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic buttonInA_b,
  input wire logic buttonInB_b,
  input wire logic holdTimeStrap,
  input wire logic resetIn,
  input wire logic resetOut,
  input wire logic resetOe_b
);
  localparam bit LVL = VARIANT == lprt_pkg::LPRT_VAR_LEVEL;
  // pulse ends on the PULSE_MS-th tick after entry, so up to one tick short
  localparam int PMIN = int'((PULSE_MS - 1) * TICK_CYCLES + 1);
  localparam int PMAX = int'(PULSE_MS * TICK_CYCLES);
  logic prs;
  logic seen;
  logic strapQ;
  int lowCnt;
  int upCnt;
  int pulseCnt;
  int holdC;
  assign prs = !buttonInA_b && (VARIANT == lprt_pkg::LPRT_VAR_PULSE1 || !buttonInB_b);
  assign holdC = int'((strapQ ? HOLD_HIGH_MS : HOLD_LOW_MS) * TICK_CYCLES);
  // seen: some input went high since the last assertion
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt <= 0;
      upCnt <= 0;
      pulseCnt <= 0;
      seen <= 1'b1;
      strapQ <= 1'b0;
    end else begin
      lowCnt <= prs ? lowCnt + 1 : 0;
      if (upCnt < 1000) upCnt <= upCnt + 1;
      pulseCnt <= resetOe_b ? 0 : pulseCnt + 1;
      // level variant: the release that ends the reset is itself the re-arm
      if (!resetOe_b && (!LVL || prs)) seen <= 1'b0;
      else if (!prs) seen <= 1'b1;
      if (!prs || upCnt <= int'(STARTUP_CYCLES)) strapQ <= holdTimeStrap;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_out; !resetOe_b |-> resetOut == 1'b0; endproperty
  a_out: assert property (p_out) else $error("reset driven high");
  property p_hold; $fell(resetOe_b) |-> lowCnt + int'(TICK_CYCLES) >= holdC; endproperty
  a_hold: assert property (p_hold) else $error("reset before hold time");
  property p_lvlRel; LVL && !resetOe_b && !prs |-> ##[0:5] resetOe_b; endproperty
  a_lvlRel: assert property (p_lvlRel) else $error("level reset not released");
  property p_pulseLen;
    !LVL && $rose(resetOe_b) |-> pulseCnt >= PMIN && pulseCnt <= PMAX;
  endproperty
  a_pulseLen: assert property (p_pulseLen) else $error("pulse length wrong");
  property p_pulseMin; !LVL && $fell(resetOe_b) |=> !resetOe_b [*8]; endproperty
  a_pulseMin: assert property (p_pulseMin) else $error("pulse cut short");
  property p_startup; !resetOe_b |-> upCnt > int'(STARTUP_CYCLES); endproperty
  a_startup: assert property (p_startup) else $error("reset during start-up");
  property p_rearm; $fell(resetOe_b) |-> seen; endproperty
  a_rearm: assert property (p_rearm) else $error("reset without re-arm");
  property p_press; $fell(resetOe_b) |-> $past(prs, 3); endproperty
  a_press: assert property (p_press) else $error("reset while released");
endmodule : lprt_top_chk

bind lprt_top lprt_top_chk #(.VARIANT(VARIANT), .TICK_CYCLES(TICK_CYCLES),
  .STARTUP_CYCLES(STARTUP_CYCLES), .HOLD_HIGH_MS(HOLD_HIGH_MS),
  .HOLD_LOW_MS(HOLD_LOW_MS), .PULSE_MS(PULSE_MS)) u_chk (.clk(clk), .rst_b(rst_b),
  .buttonInA_b(buttonInA_b), .buttonInB_b(buttonInB_b), .holdTimeStrap(holdTimeStrap),
  .resetIn(resetIn), .resetOut(resetOut), .resetOe_b(resetOe_b));

// file: tb/lprt_btn_model.sv
`timescale 1ns/1ps
module lprt_btn_model (
  input wire logic pressA,
  input wire logic pressB,
  input wire logic [2:0] resetOe_b,
  input wire logic [2:0] resetOut,
  output logic buttonInA_b,
  output logic buttonInB_b,
  output logic [2:0] resetWire
);
  // open contacts are lifted by their pull-ups
  assign buttonInA_b = !pressA;
  assign buttonInB_b = !pressB;
  // wired reset line: the pull-up wins unless a driver is enabled
  always_comb begin
    for (int i = 0; i < 3; i++) resetWire[i] = resetOe_b[i] ? 1'b1 : resetOut[i];
  end
endmodule : lprt_btn_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_b, pressA, pressB, strap, btnA_b, btnB_b;
  logic [2:0] oeB, odOut, rw;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  // lines: [2] level, [1] dual pulse, [0] single pulse
  for (genvar i = 0; i < 3; i++) begin : g_dut
    lprt_top #(.VARIANT(lprt_pkg::lprt_variant_e'(2 - i)), .TICK_CYCLES(4),
      .STARTUP_CYCLES(8), .HOLD_HIGH_MS(i == 2 ? 10 : 0), .HOLD_LOW_MS(6),
      .PULSE_MS(8)) u_dut (.clk(clk), .rst_b(rst_b), .buttonInA_b(btnA_b),
      .buttonInB_b(btnB_b), .holdTimeStrap(strap), .resetIn(rw[i]),
      .resetOut(odOut[i]), .resetOe_b(oeB[i]));
  end
  lprt_btn_model u_btn (.pressA(pressA), .pressB(pressB), .resetOe_b(oeB),
    .resetOut(odOut), .buttonInA_b(btnA_b), .buttonInB_b(btnB_b), .resetWire(rw));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task chk(input logic [2:0] e);
    n_compared++;
    if (rw !== e) begin
      mismatches++;
      $display("ERROR %0t reset lines %b expected %b", $time, rw, e);
    end
  endtask : chk
  task go(input int n);
    repeat (t0 + n - cyc) @(posedge clk);
    #2;
  endtask : go
  task prs(input logic a, input logic b);
    pressA = a;
    pressB = b;
  endtask : prs
  task t_startup();
    t0 = cyc;
    go(6); chk(3'b111);
    go(30); chk(3'b100);
    prs(0, 0); go(60); chk(3'b111);
    strap = 1'b0;
    go(64);
  endtask : t_startup
  task t_pulse();
    t0 = cyc;
    prs(1, 1); go(18); chk(3'b111);
    go(36); chk(3'b000);
    go(40); prs(0, 1); go(46); chk(3'b100);
    go(52); chk(3'b100);
    go(74); chk(3'b111);
    prs(0, 0); go(80);
  endtask : t_pulse
  task t_rearm();
    t0 = cyc;
    prs(1, 1); go(40); prs(0, 1); go(43); prs(1, 1);
    go(100); chk(3'b011);
    prs(1, 0); go(106); prs(1, 1); go(144); chk(3'b001);
    prs(0, 0); go(190);
  endtask : t_rearm
  task t_strap();
    t0 = cyc;
    prs(1, 1); go(5); strap = 1'b1; go(18); chk(3'b111);
    go(36); chk(3'b000);
    prs(0, 0); go(80); t0 = cyc;
    prs(1, 1); go(12); chk(3'b100);
    go(32); chk(3'b100);
    go(52); chk(3'b011);
    prs(0, 0); go(60); strap = 1'b0;
  endtask : t_strap
  initial begin
    rst_b = 1'b0;
    prs(1, 1);
    strap = 1'b1;
    repeat (16) @(posedge clk);
    #2;
    rst_b = 1'b1;
    t_startup();
    t_pulse();
    t_rearm();
    t_strap();
    end_sim();
  end
  initial begin
    #75000;
    mismatches++;
    end_sim();
  end
endmodule : tb_top
